// ==== rtl/omgmt_port.v ====
/*
 * Management and control port of a pluggable optical module: two-wire
 * serial slave into a byte memory, live readings and alarm flags,
 * laser disable with timed switch, standby and pin-driven reset.
 * Assumes the host makes the serial clock, and that pins are resolved
 * outside; the serial data pin is open drain (oe low means pull low).
 */
`timescale 1ns/1ps
`include "omgmt_regs.vh"

module omgmt_port #(
    parameter OFF_CYCLES = (`OMGMT_T_OFF_MS * `OMGMT_CLK_KHZ),
    parameter ON_CYCLES = (`OMGMT_T_ON_MS * `OMGMT_CLK_KHZ),
    parameter MEM_DEPTH = 256
) (
    input wire i_clock,
    input wire i_resetn,
    input wire i_scl,
    input wire i_sda,
    input wire i_select_n,
    input wire i_laser_off_request,
    input wire i_power_down,
    input wire i_rx_signal_lost,
    input wire [15:0] i_temp,
    input wire [15:0] i_bias,
    input wire [15:0] i_txpwr,
    input wire [15:0] i_rxpwr,
    input wire [15:0] i_vcc,
    input wire [7:0] i_alarm,
    input wire [7:0] i_warn,
    output reg o_sda_oe_n,
    output reg o_interrupt_n,
    output reg o_laser_enable,
    output reg o_module_absent,
    output reg o_module_not_ready_flag,
    output reg o_receive_signal_lost,
    output reg o_standby
);
    // States of the serial slave, one-hot
    localparam ST_IDLE = 5'b00001;
    localparam ST_DEVADR = 5'b00010;
    localparam ST_WADDR = 5'b00100;
    localparam ST_WDATA = 5'b01000;
    localparam ST_RDATA = 5'b10000;

    // Synchronised pins
    wire scl_s;
    wire sda_s;
    wire sel_n_s;
    wire laser_off_s;
    wire pdown_s;
    wire los_s;

    omgmt_sync #(.RESET_VALUE(1'b1)) u_scl (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_async(i_scl), .o_sync(scl_s));
    omgmt_sync #(.RESET_VALUE(1'b1)) u_sda (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_async(i_sda), .o_sync(sda_s));
    omgmt_sync #(.RESET_VALUE(1'b1)) u_sel (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_async(i_select_n), .o_sync(sel_n_s));
    omgmt_sync #(.RESET_VALUE(1'b1)) u_txd (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_async(i_laser_off_request), .o_sync(laser_off_s));
    omgmt_sync #(.RESET_VALUE(1'b1)) u_pdn (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_async(i_power_down), .o_sync(pdown_s));
    omgmt_sync #(.RESET_VALUE(1'b1)) u_los (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_async(i_rx_signal_lost), .o_sync(los_s));

    // Previous samples for edge finding
    reg scl_d;
    reg sda_d;
    reg pdown_d;
    // Edges and bus conditions
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire pdown_fall = ~pdown_s & pdown_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    // Soft reset pulse from power down falling edge
    wire soft_rst = pdown_fall;

    reg [7:0] mem [0:MEM_DEPTH-1];
    // Serial slave state
    reg [4:0] state;
    reg [7:0] shift;
    reg [3:0] bit_cnt;
    reg ack_phase;
    reg rd_dir;
    reg [7:0] addr;
    reg [7:0] mask;
    reg [7:0] rd_byte;
    // Laser and init counters
    reg [31:0] laser_cnt;
    reg [15:0] init_cnt;
    wire ready = (init_cnt == `OMGMT_INIT_CYCLES);

    // live readings mapped ahead of the memory
    always @* begin
        case (addr)
            `OMGMT_ADDR_TEMP: rd_byte = i_temp[15:8];
            8'h61: rd_byte = i_temp[7:0];
            `OMGMT_ADDR_BIAS: rd_byte = i_bias[15:8];
            8'h63: rd_byte = i_bias[7:0];
            `OMGMT_ADDR_TXPWR: rd_byte = i_txpwr[15:8];
            8'h65: rd_byte = i_txpwr[7:0];
            `OMGMT_ADDR_RXPWR: rd_byte = i_rxpwr[15:8];
            8'h67: rd_byte = i_rxpwr[7:0];
            `OMGMT_ADDR_VCC: rd_byte = i_vcc[15:8];
            8'h69: rd_byte = i_vcc[7:0];
            `OMGMT_ADDR_ALARM: rd_byte = i_alarm;
            `OMGMT_ADDR_WARN: rd_byte = i_warn;
            `OMGMT_ADDR_MASK: rd_byte = mask;
            `OMGMT_ADDR_STATUS: rd_byte = {4'h0, o_standby, o_module_not_ready_flag,
                o_receive_signal_lost, ~o_laser_enable};
            default: rd_byte = mem[addr];
        endcase
    end

    // Edge history
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            pdown_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            pdown_d <= pdown_s;
        end
    end

    // Memory writes, no reset needed
    always @(posedge i_clock) begin
        if (state == ST_WDATA && scl_rise && !ack_phase && bit_cnt == 4'h7
                && addr >= `OMGMT_ADDR_WR_LOW)
            mem[addr] <= {shift[6:0], sda_s};
    end

    // Serial slave; the clock is only ever sampled
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            rd_dir <= 1'b0;
            addr <= 8'h00;
            mask <= `OMGMT_MASK_RESET;
            o_sda_oe_n <= 1'b1;
        end else if (soft_rst) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            rd_dir <= 1'b0;
            addr <= 8'h00;
            mask <= `OMGMT_MASK_RESET;
            o_sda_oe_n <= 1'b1;
        end else if (sel_n_s || pdown_s || !ready) begin
            state <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
        end else if (start_cond) begin
            state <= ST_DEVADR;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
        end else if (scl_rise && !ack_phase && state != ST_IDLE) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
            // Host acknowledge of a read byte
            if (state == ST_RDATA && bit_cnt == 4'h8) begin
                if (sda_s)
                    state <= ST_IDLE;
                bit_cnt <= 4'h0;
            end
        end else if (scl_fall && state != ST_IDLE) begin
            // change outgoing data on falling edge
            if (ack_phase) begin
                ack_phase <= 1'b0;
                o_sda_oe_n <= 1'b1;
                bit_cnt <= 4'h0;
                if (state == ST_RDATA)
                    o_sda_oe_n <= rd_byte[7];
            end else if (state == ST_RDATA && bit_cnt < 4'h8) begin
                o_sda_oe_n <= rd_byte[3'h7 - bit_cnt[2:0]];
                if (bit_cnt == 4'h7)
                    addr <= addr + 8'h01;
            end else if (state == ST_RDATA) begin
                o_sda_oe_n <= 1'b1;
            end else if (bit_cnt == 4'h8) begin
                ack_phase <= 1'b1;
                o_sda_oe_n <= 1'b0;
                case (state)
                    ST_DEVADR: begin
                        if (shift[7:1] != `OMGMT_DEV_ADDR) begin
                            state <= ST_IDLE;
                            o_sda_oe_n <= 1'b1;
                            ack_phase <= 1'b0;
                        end else begin
                            rd_dir <= shift[0];
                            state <= shift[0] ? ST_RDATA : ST_WADDR;
                        end
                    end
                    ST_WADDR: begin
                        addr <= shift;
                        state <= ST_WDATA;
                    end
                    default: begin
                        if (addr == `OMGMT_ADDR_MASK)
                            mask <= shift;
                        addr <= addr + 8'h01;
                    end
                endcase
            end
        end
    end

    // Laser control, init and status outputs
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            laser_cnt <= 32'h0;
            init_cnt <= 16'h0;
            o_laser_enable <= 1'b0;
            o_module_not_ready_flag <= 1'b1;
            o_standby <= 1'b1;
            o_receive_signal_lost <= 1'b1;
            o_interrupt_n <= 1'b1;
            o_module_absent <= 1'b0;
        end else begin
            o_module_absent <= 1'b0;
            o_standby <= pdown_s;
            // loss flag, 1 means no signal
            o_receive_signal_lost <= los_s;
            if (soft_rst || pdown_s)
                init_cnt <= 16'h0;
            else if (!ready)
                init_cnt <= init_cnt + 16'h1;
            o_module_not_ready_flag <= ~ready;
            o_interrupt_n <= ~(|((i_alarm | i_warn) & mask));
            if (soft_rst || pdown_s) begin
                laser_cnt <= 32'h0;
                o_laser_enable <= 1'b0;
            end else if (laser_off_s == o_laser_enable) begin
                if (laser_cnt >= (laser_off_s ? OFF_CYCLES - 1 : ON_CYCLES - 1)) begin
                    laser_cnt <= 32'h0;
                    o_laser_enable <= ~laser_off_s;
                end else begin
                    laser_cnt <= laser_cnt + 32'h1;
                end
            end else begin
                laser_cnt <= 32'h0;
            end
        end
    end
endmodule // omgmt_port

// ==== rtl/omgmt_regs.vh ====
/*
 * Constants for the optical module management port: memory layout,
 * flag positions and timing counts.
 * Assumes a 20 MHz system clock; included by the port module (not the synchroniser) and by the host model and top bench.
 */
`ifndef OMGMT_REGS_VH
`define OMGMT_REGS_VH

// Serial device address (7 bits, read/write bit excluded)
`define OMGMT_DEV_ADDR 7'h50
// Memory offsets of live readings (two bytes each, high byte first)
`define OMGMT_ADDR_TEMP 8'h60
`define OMGMT_ADDR_BIAS 8'h62
`define OMGMT_ADDR_TXPWR 8'h64
`define OMGMT_ADDR_RXPWR 8'h66
`define OMGMT_ADDR_VCC 8'h68
// Alarm flags, warning flags, flag enable mask, status byte
`define OMGMT_ADDR_ALARM 8'h50
`define OMGMT_ADDR_WARN 8'h51
`define OMGMT_ADDR_MASK 8'h52
`define OMGMT_ADDR_STATUS 8'h6E
// Lowest writable address besides the flag enable mask; below it the memory is write protected
`define OMGMT_ADDR_WR_LOW 8'h80
// Reset value of the flag enable mask
`define OMGMT_MASK_RESET 8'hFF
// Status byte bit positions
`define OMGMT_ST_LASER_OFF 0
`define OMGMT_ST_LOS 1
`define OMGMT_ST_NOT_READY 2
`define OMGMT_ST_STANDBY 3
// Laser switch times, in milliseconds
`define OMGMT_T_OFF_MS 100
`define OMGMT_T_ON_MS 100
// Clock rate in kHz
`define OMGMT_CLK_KHZ 20000
// Cycles the management logic needs to initialise after reset
`define OMGMT_INIT_CYCLES 16'h0100

`endif

// ==== rtl/omgmt_sync.v ====
/*
 * Two-flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a plain level; output lags by two edges.
 */
`timescale 1ns/1ps

module omgmt_sync #(
    parameter RESET_VALUE = 1'b0
) (
    input wire i_clock,
    input wire i_resetn,
    input wire i_async,
    output reg o_sync
);
    // First stage, read only by the second
    reg meta;

    // Two stage capture
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule // omgmt_sync

// ==== dv/omgmt_sva.sv ====
/* Checker for the management port pins.
   Assumes it is bound onto omgmt_port and sees only its ports. */
`timescale 1ns/1ps

module omgmt_chk #(
    parameter int OFF_CYCLES = 50,
    parameter int ON_CYCLES = 50
) (
    input wire i_clock,
    input wire i_resetn,
    input wire i_scl,
    input wire i_select_n,
    input wire i_laser_off_request,
    input wire i_power_down,
    input wire i_rx_signal_lost,
    input wire [7:0] i_alarm,
    input wire [7:0] i_warn,
    input wire o_sda_oe_n,
    input wire o_interrupt_n,
    input wire o_laser_enable,
    input wire o_module_absent,
    input wire o_module_not_ready_flag,
    input wire o_receive_signal_lost,
    input wire o_standby
);
    // Switch bounds with synchroniser slack
    localparam int OFF_MAX = OFF_CYCLES + 8;
    localparam int ON_MAX = ON_CYCLES + 8;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // Steady input levels
    sequence s_los_hi; i_rx_signal_lost [*5]; endsequence
    sequence s_los_lo; !i_rx_signal_lost [*5]; endsequence
    sequence s_no_flag; (i_alarm == 8'h00 && i_warn == 8'h00) [*5]; endsequence
    sequence s_desel; i_select_n [*5]; endsequence
    sequence s_pd_hi; i_power_down [*5]; endsequence
    a_absent_grounded: assert property (!o_module_absent)
        else $error("absent pin not low");
    a_laser_off_time: assert property ($rose(i_laser_off_request) |-> ##[1:OFF_MAX] !o_laser_enable)
        else $error("laser not off in time");
    a_laser_on_time: assert property ($fell(i_laser_off_request) && !i_power_down |->
        ##[1:ON_MAX] o_laser_enable)
        else $error("laser not on in time");
    a_los_high: assert property (s_los_hi |-> o_receive_signal_lost)
        else $error("loss output not high");
    a_los_low: assert property (s_los_lo |-> !o_receive_signal_lost)
        else $error("loss output not low");
    a_irq_release: assert property (s_no_flag |-> o_interrupt_n)
        else $error("interrupt without flag");
    a_desel_quiet: assert property (s_desel |-> o_sda_oe_n)
        else $error("data pulled while deselected");
    a_sda_on_fall: assert property ($changed(o_sda_oe_n) && !i_select_n && !i_power_down |->
        $past(!i_scl, 2))
        else $error("data changed with clock high");
    a_not_ready_quiet: assert property (o_module_not_ready_flag |-> o_sda_oe_n)
        else $error("bus answered while not ready");
    a_pd_edge_reset: assert property ($fell(i_power_down) |-> ##[1:8] o_module_not_ready_flag)
        else $error("no reset on power down fall");
    a_standby_held: assert property (s_pd_hi |-> o_standby)
        else $error("standby not shown");
endmodule // omgmt_chk

// ==== dv/omgmt_host.sv ====
/* Host board model: serial clock and data master.
   Assumes SDA pulled up; the module pulls low while oe_n is low. */
`timescale 1ns/1ps
`include "omgmt_regs.vh"

module omgmt_host (
    input wire i_clock,
    input wire i_sda_oe_n,
    output logic o_scl,
    output wire o_sda
);
    localparam logic [7:0] DW = {`OMGMT_DEV_ADDR, 1'b0};
    logic sda_h = 1'b1; // Host drive, 1 releases
    initial o_scl = 1'b1;
    assign o_sda = sda_h & i_sda_oe_n;
    // Wait on falling system edges
    task tk(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task bw(input logic b);
        sda_h = b;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        o_scl = 1'b0;
        tk(2);
    endtask
    // Read one bit mid-high
    task br(output logic b);
        sda_h = 1'b1;
        tk(2);
        o_scl = 1'b1;
        tk(2);
        b = o_sda;
        tk(2);
        o_scl = 1'b0;
        tk(2);
    endtask
    task st;
        sda_h = 1'b1;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        sda_h = 1'b0;
        tk(4);
        o_scl = 1'b0;
        tk(2);
    endtask
    task sp;
        sda_h = 1'b0;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        sda_h = 1'b1;
        tk(4);
    endtask
    // Byte out MSB first, collects acknowledge
    task wb(input logic [7:0] d, inout logic ok);
        logic b;
        for (int i = 7; i >= 0; i--) bw(d[i]);
        br(b);
        ok = ok & !b;
    endtask
    // Byte in, then ack or nack
    task rb(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) br(d[i]);
        bw(last);
    endtask
    // One-byte write at an address
    task wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        ok = 1'b1;
        st();
        wb(DW, ok);
        wb(a, ok);
        wb(d, ok);
        sp();
    endtask
    // set address, then two sequential reads
    task rd(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        logic ok;
        ok = 1'b1;
        st();
        wb(DW, ok);
        wb(a, ok);
        sp();
        st();
        wb(DW | 8'h01, ok);
        rb(d0, 1'b0);
        rb(d1, 1'b1);
        sp();
    endtask
endmodule // omgmt_host

// ==== dv/omgmt_tb.sv ====
/* Top bench for the management port.
   Assumes host model and checker are compiled before it. */
`timescale 1ns/1ps
`include "omgmt_regs.vh"

module testbench;
    localparam int OFFC = 50;
    localparam int ONC = 50;
    logic i_clock = 1'b0, i_resetn = 1'b0, sel_n = 1'b0, laser_off = 1'b0;
    logic pdown = 1'b0, los = 1'b0, ok;
    logic [7:0] alarm = 8'h00, warn = 8'h00, d0, d1;
    // Live readings, distinct per channel
    logic [15:0] temp = 16'h1234, bias = 16'h5678, txpwr = 16'h9ABC, rxpwr = 16'hDEF0;
    logic [15:0] vcc = 16'h0F1E;
    wire scl, sda, oe_n, irq_n, laser_en, absent, not_rdy, los_out, stby;
    int failures = 0, num_checks = 0;
    always #25 i_clock = ~i_clock;
    omgmt_host host (.i_clock(i_clock), .i_sda_oe_n(oe_n), .o_scl(scl), .o_sda(sda));
    omgmt_port #(.OFF_CYCLES(OFFC), .ON_CYCLES(ONC)) dut (.i_clock(i_clock),
        .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda), .i_select_n(sel_n),
        .i_laser_off_request(laser_off), .i_power_down(pdown), .i_rx_signal_lost(los),
        .i_temp(temp), .i_bias(bias), .i_txpwr(txpwr), .i_rxpwr(rxpwr),
        .i_vcc(vcc), .i_alarm(alarm), .i_warn(warn), .o_sda_oe_n(oe_n),
        .o_interrupt_n(irq_n), .o_laser_enable(laser_en), .o_module_absent(absent),
        .o_module_not_ready_flag(not_rdy), .o_receive_signal_lost(los_out), .o_standby(stby));
    // Compare and count
    task check(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    // Verdict and end of run
    task results;
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Pins after reset, ready delay
    task t_reset;
        check(16'({absent, not_rdy, los_out}), 16'h0003);
        host.tk(240);
        check(16'(not_rdy), 16'h0001);
        host.tk(30);
        check(16'(not_rdy), 16'h0000);
    endtask
    // Writable and protected bytes, live reading
    task t_mem;
        host.wr(8'h80, 8'hA5, ok);
        check(16'(ok), 16'h0001);
        host.wr(8'h81, 8'h3C, ok);
        host.rd(8'h80, d0, d1);
        check({d0, d1}, 16'hA53C);
        host.wr(`OMGMT_ADDR_TEMP, 8'h00, ok);
        host.rd(`OMGMT_ADDR_TEMP, d0, d1);
        check({d0, d1}, 16'h1234);
        temp = 16'h4321;
        host.rd(`OMGMT_ADDR_TEMP, d0, d1);
        check({d0, d1}, 16'h4321);
        host.rd(`OMGMT_ADDR_BIAS, d0, d1);
        check({d0, d1}, 16'h5678);
        host.rd(`OMGMT_ADDR_TXPWR, d0, d1);
        check({d0, d1}, 16'h9ABC);
        host.rd(`OMGMT_ADDR_RXPWR, d0, d1);
        check({d0, d1}, 16'hDEF0);
        host.rd(`OMGMT_ADDR_VCC, d0, d1);
        check({d0, d1}, 16'h0F1E);
    endtask
    // Flags, mask and interrupt pin
    task t_irq;
        alarm = 8'h04;
        warn = 8'h01;
        host.tk(8);
        check(16'(irq_n), 16'h0000);
        host.rd(`OMGMT_ADDR_ALARM, d0, d1);
        check({d0, d1}, 16'h0401);
        host.wr(`OMGMT_ADDR_MASK, 8'h00, ok);
        host.tk(4);
        check(16'(irq_n), 16'h0001);
        alarm = 8'h00;
        warn = 8'h00;
    endtask
    // Deselected bus, laser and loss pins
    task t_pins;
        sel_n = 1'b1;
        host.wr(8'h82, 8'h77, ok);
        check(16'(ok), 16'h0000);
        sel_n = 1'b0;
        check(16'(laser_en), 16'h0001);
        laser_off = 1'b1;
        host.tk(OFFC + 8);
        check(16'(laser_en), 16'h0000);
        laser_off = 1'b0;
        host.tk(ONC + 8);
        check(16'(laser_en), 16'h0001);
        check(16'(los_out), 16'h0000);
        los = 1'b1;
        host.tk(6);
        check(16'(los_out), 16'h0001);
        // Status byte: only the loss bit set
        host.rd(`OMGMT_ADDR_STATUS, d0, d1);
        check(16'(d0), 16'h0001 << `OMGMT_ST_LOS);
    endtask
    // Standby, then reset on falling edge
    task t_pdown;
        pdown = 1'b1;
        host.tk(6);
        check(16'(stby), 16'h0001);
        host.wr(8'h80, 8'h11, ok);
        check(16'(ok), 16'h0000);
        pdown = 1'b0;
        host.tk(6);
        check(16'(not_rdy), 16'h0001);
        host.tk(290);
        host.rd(`OMGMT_ADDR_MASK, d0, d1);
        check(16'(d0), 16'h00FF);
    endtask
    initial begin
        repeat (2) @(negedge i_clock);
        i_resetn = 1'b1;
        t_reset();
        t_mem();
        t_irq();
        t_pins();
        t_pdown();
        results();
    end
    // Watchdog, about 40000 cycles
    initial begin
        #2000000;
        failures++;
        results();
    end
endmodule // testbench

bind omgmt_port omgmt_chk #(.OFF_CYCLES(OFF_CYCLES), .ON_CYCLES(ON_CYCLES)) u_chk (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_scl(i_scl), .i_select_n(i_select_n),
    .i_laser_off_request(i_laser_off_request), .i_power_down(i_power_down),
    .i_rx_signal_lost(i_rx_signal_lost), .i_alarm(i_alarm), .i_warn(i_warn),
    .o_sda_oe_n(o_sda_oe_n), .o_interrupt_n(o_interrupt_n), .o_laser_enable(o_laser_enable),
    .o_module_absent(o_module_absent), .o_module_not_ready_flag(o_module_not_ready_flag),
    .o_receive_signal_lost(o_receive_signal_lost), .o_standby(o_standby));
